/* test_tha_alert.sv */
// Testbench for tha_alert: register port, conversion feed and an SMBus host.
// Assumes reads answer one cycle later and SDA is pulled only while enabled.
`timescale 1ns/100ps
module test_tha_alert
   import tha_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   tha_conv_s   conv_in = '0;
   logic        cdone = 1'b0;
   logic [6:0]  own_addr = 7'h4c;
   logic        scl, sda, sda_out, sda_oe, h_oe, r_oe, al_out, al_oe;
   int          miscompares = 0;
   int          checked = 0;
   int          cycles = 0;
   int          seed = 32'h33c8;
   int          raw;
   logic [7:0]  d8;
   logic        ack;
   logic [15:0] e;

   assign sda = ~(h_oe | r_oe | (sda_oe & ~sda_out));
   always #2.5 clock = ~clock;

   tha_alert i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_in(conv_in),
      .conv_cycle_done(cdone), .own_addr(own_addr), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .thermal_alert_out(al_out),
      .thermal_alert_oe(al_oe));
   tha_smbus_host i_host (.sda(sda), .scl(scl), .sda_oe(h_oe), .rival_oe(r_oe));

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      checked++;
      if (x !== g) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic conv(input logic [1:0] c, input int r);
      @(posedge clock);
      conv_in <= '{valid: 1'b1, ch: c, raw: 17'(r)};
      @(posedge clock);
      conv_in.valid <= 1'b0;
      @(posedge clock);
      cdone <= 1'b1;
      @(posedge clock);
      cdone <= 1'b0;
   endtask
   task automatic alert(input logic x);
      repeat (4) @(posedge clock);
      #1 chk("alert_oe", x, al_oe);
      chk("alert_out", 1'b0, al_out);
   endtask
   function automatic logic [15:0] code(input int r, input logic ext);
      int t;
      t = (r - (ext ? 1024 : 0)) * 16;
      if (t > 32752) t = 32752;
      return t[15:0];
   endfunction

   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      alert(1'b0);
      rd(REG_MASK, d8);
      chk("mask", 8'h0f, d8);
      rd(8'h30, d8);
      chk("unmapped", 8'h00, d8);
      for (int f = 0; f < 2; f++) begin
         wr(REG_CONFIG, 8'(f << CFG_EXT_BIT));
         for (int k = 0; k < 10; k++) begin
            raw = (k == 0) ? 2400 : int'({$random(seed)} % 3425) - 1024;
            conv(2'(k), raw);
            e = code(raw, f[0]);
            rd(REG_TEMP_BASE | {5'h0, 2'(k), 1'b0}, d8);
            chk("temp_hi", e[15:8], d8);
            rd(REG_TEMP_BASE | {5'h0, 2'(k), 1'b1}, d8);
            chk("temp_lo", e[7:0], d8);
         end
      end
      alert(1'b0);
      $display("test format done");
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      wr(8'h22, 8'h32);
      wr(8'h23, 8'he7);
      wr(8'h24, 8'h32);
      rd(8'h22, d8);
      chk("limit_hi", 8'h32, d8);
      wr(REG_CONFIG, 8'h02);
      rd(8'h22, d8);
      chk("limit_kept", 8'h32, d8);
      wr(REG_CONFIG, 8'h00);
      wr(REG_MASK, 8'h0d);
      conv(2'd2, 960);
      alert(1'b0);
      rd(REG_STATUS_HI, d8);
      chk("status_hi", 8'h04, d8);
      conv(2'd1, 960);
      alert(1'b1);
      conv(2'd1, 1000);
      rd(8'h02, d8);
      chk("temp_hi", 8'h3e, d8);
      rd(REG_STATUS_HI, d8);
      chk("status_hi", 8'h02, d8);
      alert(1'b0);
      conv(2'd1, 1000);
      alert(1'b1);
      i_host.ara(8'hff, d8, ack);
      chk("ara_ack", 1'b1, ack);
      chk("ara_byte", {own_addr, 1'b0}, d8);
      alert(1'b0);
      conv(2'd1, -480);
      alert(1'b1);
      i_host.ara(8'h14, d8, ack);
      chk("ara_byte", 8'h14, d8);
      alert(1'b1);
      rd(REG_STATUS_LO, d8);
      chk("status_lo", 8'h02, d8);
      alert(1'b0);
      i_host.ara(8'hff, d8, ack);
      chk("ara_ack", 1'b0, ack);
      chk("ara_byte", 8'hff, d8);
      $display("test interrupt done");
      wr(REG_CONFIG, 8'h10);
      rd(REG_CONFIG, d8);
      chk("config", 8'h10, d8);
      conv(2'd1, 960);
      alert(1'b1);
      i_host.ara(8'hff, d8, ack);
      chk("ara_ack", 1'b0, ack);
      alert(1'b1);
      conv(2'd1, 784);
      alert(1'b1);
      conv(2'd1, 768);
      alert(1'b0);
      conv(2'd1, -480);
      alert(1'b1);
      conv(2'd1, -384);
      alert(1'b1);
      conv(2'd1, -368);
      alert(1'b0);
      $display("test comparator done");
      conclude();
   end
endmodule

/* tha_alert.sv */
// Thermal alert output, alert response answer and temperature formatting.
// Assumes conversion results arrive on the core clock; SMBus pins are asynchronous.
// What this block does
// - With an alert pending, the device returns its own slave address.
// - Simultaneous responders arbitrate; lower address wins, loser stops sending.
// - Loser does not acknowledge and keeps the alert line low.
// - Completed alert response clears the latch and releases the line.
// - Cleared alerts reassert at next conversion end if fault persists.
// - Alert response is answered only in interrupt mode.
// - Interrupt mode raises alert when a reading crosses high or low limit.
// - Reading a fault status clears that latched fault and, in interrupt mode, the line.
// - Alerts never halt conversions.
// - Alert output is open drain: pull low or release only.
// - Per-channel mask keeps masked faults off the alert line.
// - Config bit 4 selects interrupt (0) or comparator (1) mode.
// - Comparator mode releases the alert automatically when back in range.
// - Comparator release needs 2 degrees of margin inside both limits.
// - Values are 12-bit two's complement, 0.0625 degree LSB, two bytes.
// - Word D15 sign, D14..D4 value, D3..D0 read as zero.
// - Temperature words are sent most significant byte first.
// - Extended format stores temperature minus 64 degrees.
// - All alarms start masked after power-up.
// - Limits live in host-writable registers 20h to 27h.
`timescale 1ns/100ps
module tha_alert
   import tha_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Register port.
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Conversion results, raw value in sixteenths of a degree, signed 17 bits.
   input  wire tha_conv_s   conv_in,
   input  wire logic        conv_cycle_done,
   input  wire logic [6:0]  own_addr,
   // SMBus pins.
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // Alert pin, open drain.
   output logic             thermal_alert_out,
   output logic             thermal_alert_oe
);

   typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_SEND, ST_WAITACK, ST_SKIP} tha_ara_e;

   logic [7:0]  config_r;
   logic [3:0]  alert_channel_mask_r;
   tha_limit_s  limit_r [NUM_CH];
   logic [15:0] temp_r [NUM_CH];
   logic [3:0]  hi_flag_r, lo_flag_r, comp_r;
   logic        alert_latch_r, ara_clear;
   logic [SYNC_W-1:0] scl_s_r, sda_s_r;
   logic        scl_d_r, sda_d_r;
   tha_ara_e    ara_r;
   logic [3:0]  bit_cnt_r;
   logic [7:0]  shift_r;
   logic [7:0]  rdata_nxt;
   logic        arb_lost_r;

   function automatic logic [15:0] fmt_temp(input logic [16:0] raw, input logic ext);
      logic signed [20:0] v;
      // Raw sixteenths move up four places so that their LSB lands on D4.
      v = $signed({raw, 4'h0});
      if (ext)
         v = v - $signed({5'h00, EXT_OFFSET});
      if (v > $signed({5'h00, TEMP_MAX_CODE}))
         return TEMP_MAX_CODE;
      // The bottom is clamped too; a cold extended reading wraps positive only for raw below -64512.
      if (v < $signed({5'h1f, 16'h8000}))
         return 16'h8000;
      return v[15:0] & FRAC_ZERO_MASK;
   endfunction

   function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
      return $signed(a) > $signed(b);
   endfunction

   wire comp_mode = config_r[CFG_COMP_BIT];
   wire scl_rise  = scl_s_r[1] & ~scl_d_r;
   wire scl_fall  = ~scl_s_r[1] & scl_d_r;
   wire start_c   = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
   wire stop_c    = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

   // Pin synchronisers.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_s_r <= '1;
         sda_s_r <= '1;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[0], scl_in};
         sda_s_r <= {sda_s_r[0], sda_in};
         scl_d_r <= scl_s_r[1];
         sda_d_r <= sda_s_r[1];
      end
   end

   // Host-written configuration, mask and limits; the format bit never rewrites limits.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         config_r             <= CONFIG_RST;
         alert_channel_mask_r <= MASK_RST;
         for (int i = 0; i < NUM_CH; i++) begin
            limit_r[i] <= '{high: HIGH_LIMIT_RST, low: LOW_LIMIT_RST};
         end
      end else if (reg_wr) begin
         if (reg_addr == REG_CONFIG)
            config_r <= reg_wdata;
         if (reg_addr == REG_MASK)
            alert_channel_mask_r <= reg_wdata[NUM_CH-1:0];
         if (reg_addr >= REG_LIMIT_BASE && reg_addr <= REG_LIMIT_LAST) begin
            // Even offsets are high limits, odd are low; only whole degrees are written.
            // The lower byte is cleared so a reset fraction never lingers in a limit.
            for (int i = 0; i < NUM_CH; i++) begin
               if (reg_addr[2:1] == 2'(i)) begin
                  if (reg_addr[0])
                     limit_r[i].low <= {reg_wdata, 8'h00};
                  else
                     limit_r[i].high <= {reg_wdata, 8'h00};
               end
            end
         end
      end
   end

   // Conversion results keep flowing whatever the alert state.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_CH; i++) temp_r[i] <= '0;
      end else if (conv_in.valid) begin
         temp_r[conv_in.ch] <= fmt_temp(conv_in.raw, config_r[CFG_EXT_BIT]);
      end
   end

   // Status flags latch limit crossings; a status read clears them; set wins.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hi_flag_r <= '0;
         lo_flag_r <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            logic sh, sl;
            sh = 1'b0;
            sl = 1'b0;
            if (conv_in.valid && conv_in.ch == 2'(i)) begin
               sh = sgt(fmt_temp(conv_in.raw, config_r[CFG_EXT_BIT]), limit_r[i].high);
               sl = sgt(limit_r[i].low, fmt_temp(conv_in.raw, config_r[CFG_EXT_BIT]));
            end
            if (sh)
               hi_flag_r[i] <= 1'b1;
            else if (reg_rd && reg_addr == REG_STATUS_HI && hi_flag_r[i])
               hi_flag_r[i] <= 1'b0;
            if (sl)
               lo_flag_r[i] <= 1'b1;
            else if (reg_rd && reg_addr == REG_STATUS_LO && lo_flag_r[i])
               lo_flag_r[i] <= 1'b0;
         end
      end
   end

   // Comparator state with hysteresis.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         comp_r <= '0;
      end else if (conv_in.valid) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (conv_in.ch == 2'(i)) begin
               logic [15:0] t;
               t = fmt_temp(conv_in.raw, config_r[CFG_EXT_BIT]);
               if (sgt(t, limit_r[i].high) || sgt(limit_r[i].low, t))
                  comp_r[i] <= 1'b1;
               // Release needs the full margin; exactly 2 degrees inside counts.
               else if (!sgt(t, limit_r[i].high - HYST_CODE) &&
                        !sgt(limit_r[i].low + HYST_CODE, t))
                  comp_r[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt latch: set by an unmasked fault, cleared by status read or alert response.
   wire [3:0] int_src = (hi_flag_r | lo_flag_r) & ~alert_channel_mask_r;
   wire       status_rd = reg_rd && (reg_addr == REG_STATUS_HI || reg_addr == REG_STATUS_LO);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         alert_latch_r <= 1'b0;
      end else begin
         // A reassert at the end of a conversion round beats a clear in the same cycle.
         if (conv_cycle_done && |int_src)
            alert_latch_r <= 1'b1;
         else if ((status_rd && |int_src) || ara_clear)
            alert_latch_r <= 1'b0;
      end
   end

   // Alert pin: only pulled low, never driven high.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         thermal_alert_out <= 1'b0;
         thermal_alert_oe  <= 1'b0;
      end else begin
         thermal_alert_out <= 1'b0;
         thermal_alert_oe  <= comp_mode ? |(comp_r & ~alert_channel_mask_r) : alert_latch_r;
      end
   end

   // Alert response responder.
   assign ara_clear = (ara_r == ST_WAITACK) && scl_rise && ~sda_s_r[1] && ~arb_lost_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ara_r      <= ST_IDLE;
         bit_cnt_r  <= '0;
         shift_r    <= '0;
         arb_lost_r <= 1'b0;
         sda_out    <= 1'b0;
         sda_oe     <= 1'b0;
      end else if (stop_c) begin
         ara_r  <= ST_IDLE;
         sda_oe <= 1'b0;
      end else if (start_c) begin
         ara_r      <= ST_ADDR;
         bit_cnt_r  <= '0;
         arb_lost_r <= 1'b0;
         sda_oe     <= 1'b0;
      end else begin
         case (ara_r)
            ST_ADDR: if (scl_rise) begin
               shift_r   <= {shift_r[6:0], sda_s_r[1]};
               bit_cnt_r <= bit_cnt_r + 4'h1;
               if (bit_cnt_r == 4'h7) begin
                  // Answer only ARA reads, in interrupt mode, with an alert pending.
                  if ({shift_r[6:0], sda_s_r[1]} == {ARA_ADDR, 1'b1} && !comp_mode
                      && alert_latch_r)
                     ara_r <= ST_ACK;
                  else
                     ara_r <= ST_SKIP;
               end
            end
            ST_ACK: begin
               if (scl_fall && !sda_oe) begin
                  sda_oe <= 1'b1;
               end else if (scl_fall && sda_oe) begin
                  shift_r   <= {own_addr, 1'b0};
                  sda_oe    <= ~own_addr[6];
                  bit_cnt_r <= '0;
                  ara_r     <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (scl_rise && !sda_oe && !sda_s_r[1])
                  arb_lost_r <= 1'b1;
               if (scl_fall) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  shift_r   <= {shift_r[6:0], 1'b0};
                  if (bit_cnt_r == 4'h7 || arb_lost_r) begin
                     sda_oe <= 1'b0;
                     ara_r  <= arb_lost_r ? ST_SKIP : ST_WAITACK;
                  end else begin
                     sda_oe <= ~shift_r[6];
                  end
               end
            end
            ST_WAITACK: if (scl_rise) ara_r <= ST_SKIP;
            ST_SKIP: sda_oe <= 1'b0;
            default: ara_r <= ST_IDLE;
         endcase
      end
   end

   // Register reads, one cycle later; temperature words give upper byte at even offset.
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_addr == REG_CONFIG)
         rdata_nxt = config_r;
      else if (reg_addr == REG_MASK)
         rdata_nxt = {4'h0, alert_channel_mask_r};
      else if (reg_addr == REG_STATUS_HI)
         rdata_nxt = {4'h0, hi_flag_r};
      else if (reg_addr == REG_STATUS_LO)
         rdata_nxt = {4'h0, lo_flag_r};
      else if (reg_addr <= REG_TEMP_LAST)
         rdata_nxt = reg_addr[0] ? temp_r[reg_addr[2:1]][7:0]
                                 : temp_r[reg_addr[2:1]][15:8];
      else if (reg_addr >= REG_LIMIT_BASE && reg_addr <= REG_LIMIT_LAST)
         rdata_nxt = reg_addr[0] ? limit_r[reg_addr[2:1]].low[15:8]
                                 : limit_r[reg_addr[2:1]].high[15:8];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
   end

   property p_alert_release;
      @(posedge clock) disable iff (rst)
         (!comp_mode && status_rd && |int_src && !conv_cycle_done) |=> ##1 !thermal_alert_oe;
   endproperty
   a_alert_release: assert property (p_alert_release) else $error("alert not released");

   property p_masked;
      @(posedge clock) disable iff (rst)
         (alert_channel_mask_r == 4'hf && !alert_latch_r && !comp_mode) |=> !thermal_alert_oe;
   endproperty
   a_masked: assert property (p_masked) else $error("masked alert drove pin");

   property p_drain;
      @(posedge clock) disable iff (rst) thermal_alert_out == 1'b0;
   endproperty
   a_drain: assert property (p_drain) else $error("alert driven high");

   property p_no_ara_comp;
      @(posedge clock) disable iff (rst) comp_mode |-> !(ara_r == ST_ACK && $past(ara_r) == ST_ADDR);
   endproperty
   a_no_ara_comp: assert property (p_no_ara_comp) else $error("ARA answered in comparator");

   property p_low_nibble;
      @(posedge clock) disable iff (rst)
         $past(reg_rd) && $past(reg_addr) <= REG_TEMP_LAST && $past(reg_addr[0]) |-> reg_rdata[3:0] == 4'h0;
   endproperty
   a_low_nibble: assert property (p_low_nibble) else $error("fraction nibble not zero");

   property p_lost_quiet;
      @(posedge clock) disable iff (rst) arb_lost_r && ara_r == ST_SKIP |-> !sda_oe;
   endproperty
   a_lost_quiet: assert property (p_lost_quiet) else $error("loser still drives");

   property p_ara_clear;
      @(posedge clock) disable iff (rst) ara_clear && !conv_cycle_done |=> !alert_latch_r;
   endproperty
   a_ara_clear: assert property (p_ara_clear) else $error("ARA did not clear");

   property p_reassert;
      @(posedge clock) disable iff (rst) conv_cycle_done && |int_src |=> alert_latch_r;
   endproperty
   a_reassert: assert property (p_reassert) else $error("no reassert");

   // A channel above its high limit minus the margin keeps its comparator state.
   property p_hyst_hold;
      @(posedge clock) disable iff (rst)
         conv_in.valid && comp_r[conv_in.ch]
         && sgt(fmt_temp(conv_in.raw, config_r[CFG_EXT_BIT]),
                limit_r[conv_in.ch].high - HYST_CODE) |=> comp_r[$past(conv_in.ch)];
   endproperty
   a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis ignored");

   property p_pending_only;
      @(posedge clock) disable iff (rst)
         ara_r == ST_ADDR && scl_rise && bit_cnt_r == 4'h7 && !alert_latch_r
         |=> ara_r == ST_SKIP;
   endproperty
   a_pending_only: assert property (p_pending_only) else $error("answered without alert");

   property p_arb_stop;
      @(posedge clock) disable iff (rst)
         ara_r == ST_SEND && scl_rise && !sda_oe && !sda_s_r[1] |=> arb_lost_r;
   endproperty
   a_arb_stop: assert property (p_arb_stop) else $error("lost arbitration missed");

   property p_flag_set;
      @(posedge clock) disable iff (rst)
         conv_in.valid
         && sgt(fmt_temp(conv_in.raw, config_r[CFG_EXT_BIT]), limit_r[conv_in.ch].high)
         |=> hi_flag_r[$past(conv_in.ch)];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("high crossing not flagged");

   // With every unmasked channel back in range the comparator output lets go.
   property p_comp_idle;
      @(posedge clock) disable iff (rst)
         comp_mode && !(|(comp_r & ~alert_channel_mask_r)) |=> !thermal_alert_oe;
   endproperty
   a_comp_idle: assert property (p_comp_idle) else $error("comparator alert stuck");
endmodule

/* tha_pkg.sv */
// Package for the thermal alert and temperature format block.
// Assumes a single 200 MHz core clock and a slow SMBus whose pins are sampled.
package tha_pkg;
   localparam int          NUM_CH         = 4;
   localparam logic [6:0]  ARA_ADDR       = 7'h19;
   localparam logic [7:0]  REG_HIGHEST    = 8'h10;
   localparam logic [7:0]  REG_CONFIG     = 8'h13;
   localparam logic [7:0]  REG_MASK       = 8'h14;
   localparam logic [7:0]  REG_STATUS_HI  = 8'h15;
   localparam logic [7:0]  REG_STATUS_LO  = 8'h16;
   localparam logic [7:0]  REG_LIMIT_BASE = 8'h20;
   localparam logic [7:0]  REG_LIMIT_LAST = 8'h27;
   localparam logic [7:0]  REG_TEMP_BASE  = 8'h00;
   localparam logic [7:0]  REG_TEMP_LAST  = 8'h07;
   localparam int          CFG_COMP_BIT   = 4;
   localparam int          CFG_EXT_BIT    = 1;
   localparam logic [7:0]  CONFIG_RST     = 8'h00;
   localparam logic [3:0]  MASK_RST       = 4'hf;
   localparam logic [15:0] HYST_CODE      = 16'h0200;
   localparam logic [15:0] EXT_OFFSET     = 16'h4000;
   localparam logic [15:0] TEMP_MAX_CODE  = 16'h7ff0;
   localparam logic [15:0] LOW_LIMIT_RST  = 16'hc000;
   localparam logic [15:0] HIGH_LIMIT_RST = 16'h7ff0;
   localparam logic [15:0] FRAC_ZERO_MASK = 16'hfff0;
   localparam int          SYNC_W         = 2;

   typedef struct packed {
      logic [15:0] high;
      logic [15:0] low;
   } tha_limit_s;

   typedef struct packed {
      logic       valid;
      logic [1:0] ch;
      logic [16:0] raw;
   } tha_conv_s;
endpackage

/* tha_smbus_host.sv */
// SMBus host model that drives SCL and pulls SDA low, plus one rival responder.
// Assumes SDA has a pull-up and that SCL rests high between frames.
`timescale 1ns/100ps
module tha_smbus_host
   import tha_pkg::*;
(
   // Bus lines.
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe,
   // Rival slave pull-down.
   output logic      rival_oe
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
      rival_oe = 1'b0;
   end

   // Sets both pull-downs while SCL is low and samples the line in mid high phase.
   task automatic clk_bit(input logic hb, input logic rb, output logic s);
      #31.25 sda_oe = ~hb;
      rival_oe = ~rb;
      #31.25 scl = 1'b1;
      #31.25 s = sda;
      #31.25 scl = 1'b0;
   endtask

   // Receive byte at the alert response address; a rival byte of ff means no rival.
   task automatic ara(input logic [7:0] rival, output logic [7:0] d, output logic ack);
      logic       s;
      logic [7:0] a;
      a = {ARA_ADDR, 1'b1};
      sda_oe = 1'b1;
      #62.5 scl = 1'b0;
      for (int i = 7; i >= 0; i--) clk_bit(a[i], 1'b1, s);
      clk_bit(1'b1, rival == 8'hff, s);
      ack = ~s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, rival[i], s);
         d[i] = s;
      end
      clk_bit(1'b0, 1'b1, s);
      #31.25 sda_oe = 1'b1;
      #31.25 scl = 1'b1;
      #31.25 sda_oe = 1'b0;
      #62.5;
   endtask
endmodule
